// >>> hw/epf_consts.svh
// constants for the eavesdrop port filter
// assumes byte-wide receive stream, destination address first after sfd
`ifndef EPF_CONSTS_SVH
`define EPF_CONSTS_SVH
`define EPF_DA_BYTES    6
`define EPF_CNT_W       3
`define EPF_ADDR_W      48
`define EPF_DISRUPT     8'h55
`define EPF_BCAST_ADDR  48'hFFFF_FFFF_FFFF
`define EPF_MCAST_BIT   40
`endif

// >>> hw/epf_filter.sv
// eavesdrop protection filter for every transmit port of a repeater
// assumes one byte strobe at most every third clock, config held per packet
//
// What this block does
// - with protection on, only matching ports and the exemptions below pass.
// - insecure ports send alternating one-zero bits instead of content.
// - a port matches if destination equals its last or preferred source.
// - a per-port mask exempts that port from disruption.
// - a per-port multicast mask keeps multicast packets undisturbed.
// - broadcast destinations pass unaltered on every port.
// - per-port option passes non-matching packets if nobody matches.
// - repeater-wide match merges local matches with expansion bus peers.
`include "epf_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module epf_filter
    import epf_pkg::*;
#(
    parameter int N_PORTS = 5
)
(
    input  wire logic                        REF_CLK,
    input  wire logic                        RESET,
    input  wire logic                        RX_SOF,
    input  wire logic                        RX_VALID,
    input  wire logic [7:0]                  RX_DATA,
    input  wire logic                        RX_END,
    input  wire logic                        PROT_EN,
    input  wire logic [N_PORTS-1:0]          PORT_MASK,
    input  wire logic [N_PORTS-1:0]          MCAST_MASK,
    input  wire logic [N_PORTS-1:0]          PASS_NOMATCH,
    input  wire logic [N_PORTS*48-1:0]       LAST_SA,
    input  wire logic [N_PORTS*48-1:0]       PREF_SA,
    input  wire logic                        EXP_MATCH_IN,
    output logic                             EXP_MATCH_OUT,
    output logic                             TX_VALID,
    output logic [N_PORTS*8-1:0]             TX_DATA,
    output logic                             TX_END
);

    localparam int NB = `EPF_DA_BYTES;
    localparam int AW = `EPF_ADDR_W;

    // ==========================================================
    // state
    epf_state_t                  st_q, st_d;
    logic [`EPF_CNT_W-1:0]       fill_q, fill_d;
    logic [7:0]                  dly_q [NB];
    logic [7:0]                  dly_d [NB];
    logic [`EPF_ADDR_W-1:0]      da_q, da_d;
    logic                        xo_q, xo_d;
    logic [N_PORTS-1:0]          scr_q, scr_d;
    logic                        tv_q, tv_d;
    logic                        te_q, te_d;
    logic [N_PORTS*8-1:0]        td_q, td_d;
    logic [N_PORTS-1:0]          match;
    logic [N_PORTS-1:0]          pass;
    logic [N_PORTS-1:0]          ok_data;
    logic                        any_match;
    logic                        is_bcast;
    logic                        is_mcast;

    // ==========================================================
    // per-port decision
    assign is_bcast  = (da_q == `EPF_BCAST_ADDR);
    assign is_mcast  = da_q[`EPF_MCAST_BIT];
    assign any_match = (|match) | EXP_MATCH_IN;

    genvar gi;
    generate
        for (gi = 0; gi < N_PORTS; gi++)
        begin : g_port
            assign match[gi] = (da_q == LAST_SA[gi*AW +: AW]) ||
                               (da_q == PREF_SA[gi*AW +: AW]);
            assign pass[gi] = !PROT_EN
                || is_bcast
                || PORT_MASK[gi]
                || (is_mcast && MCAST_MASK[gi])
                || match[gi]
                || (PASS_NOMATCH[gi] && !any_match);
            assign ok_data[gi] = !scr_q[gi] ||
                                 (td_q[gi*8 +: 8] == `EPF_DISRUPT);
        end
    endgenerate

    // ==========================================================
    // sequencing and delay line
    always_comb
    begin
        logic       push;
        logic [7:0] byte_out;
        push     = 1'b0;
        byte_out = 8'h00;
        st_d     = st_q;
        fill_d   = fill_q;
        dly_d    = dly_q;
        da_d     = da_q;
        xo_d     = xo_q;
        scr_d    = scr_q;
        tv_d     = 1'b0;
        te_d     = 1'b0;
        case (st_q)
            S_IDLE:
            begin
                if (RX_SOF && RX_VALID)
                begin
                    push   = 1'b1;
                    fill_d = `EPF_CNT_W'(1);
                    scr_d  = '0;
                    xo_d   = 1'b0;
                    st_d   = S_COLLECT;
                end
            end
            S_COLLECT:
            begin
                // runt without full address is flushed unaltered
                if (RX_END)
                    st_d = S_FLUSH;
                else if (RX_VALID)
                begin
                    push   = 1'b1;
                    fill_d = fill_q + `EPF_CNT_W'(1);
                    if (fill_q == `EPF_CNT_W'(NB - 1))
                        st_d = S_SHARE;
                end
            end
            S_SHARE:
            begin
                xo_d = |match;
                st_d = S_DECIDE;
            end
            S_DECIDE:
            begin
                // peers drive their match in the same cycle as ours
                scr_d = ~pass;
                st_d  = S_PASS;
            end
            S_PASS:
            begin
                if (RX_END)
                    st_d = S_FLUSH;
                else if (RX_VALID)
                begin
                    push     = 1'b1;
                    tv_d     = 1'b1;
                    byte_out = dly_q[NB-1];
                end
            end
            S_FLUSH:
            begin
                if (fill_q == '0)
                begin
                    te_d = 1'b1;
                    xo_d = 1'b0;
                    st_d = S_IDLE;
                end
                else
                begin
                    tv_d     = 1'b1;
                    byte_out = dly_q[fill_q - `EPF_CNT_W'(1)];
                    fill_d   = fill_q - `EPF_CNT_W'(1);
                end
            end
            default:
                st_d = S_IDLE;
        endcase
        if (push)
        begin
            da_d     = {da_q[`EPF_ADDR_W-9:0], RX_DATA};
            dly_d[0] = RX_DATA;
            for (int k = 1; k < NB; k++)
                dly_d[k] = dly_q[k-1];
        end
        // the six destination bytes are held back, so disruption covers every byte
        for (int p = 0; p < N_PORTS; p++)
            td_d[p*8 +: 8] = scr_q[p] ? `EPF_DISRUPT : byte_out;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RESET)
        begin
            st_q   <= S_IDLE;
            fill_q <= '0;
            da_q   <= '0;
            xo_q   <= 1'b0;
            scr_q  <= '0;
            tv_q   <= 1'b0;
            te_q   <= 1'b0;
            td_q   <= '0;
            for (int k = 0; k < NB; k++)
                dly_q[k] <= 8'h00;
        end
        else
        begin
            st_q   <= st_d;
            fill_q <= fill_d;
            da_q   <= da_d;
            xo_q   <= xo_d;
            scr_q  <= scr_d;
            tv_q   <= tv_d;
            te_q   <= te_d;
            td_q   <= td_d;
            dly_q  <= dly_d;
        end
    end

    assign EXP_MATCH_OUT = xo_q;
    assign TX_VALID      = tv_q;
    assign TX_DATA       = td_q;
    assign TX_END        = te_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    chk_prot_off_pass: assert property (
        (st_q == S_DECIDE && !PROT_EN) |=> scr_q == '0)
        else $error("protection off but port disrupted");
    chk_disrupt_pattern: assert property (
        tv_q |-> &ok_data)
        else $error("disrupted port not sending alternating bits");
    chk_match_pass: assert property (
        st_q == S_DECIDE |=> (scr_q & $past(match)) == '0)
        else $error("matching port disrupted");
    chk_port_mask: assert property (
        st_q == S_DECIDE |=> (scr_q & $past(PORT_MASK)) == '0)
        else $error("masked port disrupted");
    chk_mcast_mask: assert property (
        (st_q == S_DECIDE && is_mcast)
            |=> (scr_q & $past(MCAST_MASK)) == '0)
        else $error("multicast masked port disrupted");
    chk_bcast_pass: assert property (
        (st_q == S_DECIDE && is_bcast) |=> scr_q == '0)
        else $error("broadcast disrupted");
    chk_nomatch_pass: assert property (
        (st_q == S_DECIDE && !any_match)
            |=> (scr_q & $past(PASS_NOMATCH)) == '0)
        else $error("no-match pass port disrupted");
    chk_exp_share: assert property (
        st_q == S_SHARE |=> EXP_MATCH_OUT == $past(|match))
        else $error("expansion match not local match");
    chk_da_latency: assert property (
        (st_q == S_COLLECT && !RX_END && RX_VALID &&
         fill_q == `EPF_CNT_W'(NB - 1))
            |=> st_q == S_SHARE ##1 st_q == S_DECIDE ##1 st_q == S_PASS)
        else $error("decision not after sixth octet");
    chk_scr_hold: assert property (
        (st_q == S_PASS || st_q == S_FLUSH) |=> $stable(scr_q))
        else $error("disruption changed inside packet");

    cov_disrupt: cover property (tv_q && scr_q != '0);
    cov_bcast: cover property (st_q == S_DECIDE && is_bcast);
    cov_remote: cover property (st_q == S_DECIDE && EXP_MATCH_IN && !(|match));
    cov_end: cover property (te_q);

endmodule

`default_nettype wire

// >>> hw/epf_pkg.sv
// types for the eavesdrop port filter
// assumes epf_consts.svh is on the include path
package epf_pkg;
    typedef enum logic [5:0] {
        S_IDLE    = 6'h01,
        S_COLLECT = 6'h02,
        S_SHARE   = 6'h04,
        S_DECIDE  = 6'h08,
        S_PASS    = 6'h10,
        S_FLUSH   = 6'h20
    } epf_state_t;
endpackage

// >>> verif/epf_peer.sv
// expansion bus peers: wired-or match level from other repeater devices
// assumes WANT is set well before the destination octets finish
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// peer match driver
module epf_peer
    import epf_pkg::*;
(
    input  wire logic REF_CLK,
    input  wire logic RESET,
    input  wire logic WANT,
    input  wire logic SLOW,
    output logic      EXP_MATCH_IN
);
    logic match_d;
    logic match_q;
    logic late_q;
    // a slow peer answers one cycle later than a prompt one
    always_comb match_d = WANT;
    always_ff @(posedge REF_CLK)
    begin
        match_q <= RESET ? 1'b0 : match_d;
        late_q  <= RESET ? 1'b0 : match_q;
    end
    assign EXP_MATCH_IN = SLOW ? late_q : match_q;
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// bench: random packets and settings, every output byte checked
// assumes design under hw/ and epf_peer for the expansion bus side
`include "epf_consts.svh"
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bench top
module tb_top
    import epf_pkg::*;
;
    localparam int N = 5;
    logic clk, rst, sof, vld, eop, prot, exp_in, exp_out;
    logic tx_vld, tx_end, want, slow, first, done, any_e, hung;
    logic [7:0]     rxd;
    logic [N-1:0]   pmask, mmask, pnm, pass_e;
    logic [N*48-1:0] lsa, psa;
    logic [N*8-1:0] txd;
    logic [7:0]     pay[$];
    int             failures, compares;

    epf_filter #(.N_PORTS(N)) DUT (.REF_CLK(clk), .RESET(rst),
        .RX_SOF(sof), .RX_VALID(vld), .RX_DATA(rxd), .RX_END(eop),
        .PROT_EN(prot), .PORT_MASK(pmask), .MCAST_MASK(mmask),
        .PASS_NOMATCH(pnm), .LAST_SA(lsa), .PREF_SA(psa),
        .EXP_MATCH_IN(exp_in), .EXP_MATCH_OUT(exp_out),
        .TX_VALID(tx_vld), .TX_DATA(txd), .TX_END(tx_end));
    epf_peer PEER (.REF_CLK(clk), .RESET(rst), .WANT(want), .SLOW(slow),
        .EXP_MATCH_IN(exp_in));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
// ==========================================
// checking
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk)
    begin
        logic [N*8-1:0] e;
        logic [7:0]     b;
        if (tx_vld === 1'b1)
        begin
            check(pay.size() != 0, 1'b1);
            b = (pay.size() > 0) ? pay.pop_front() : 8'h00;
            for (int i = 0; i < N; i++)
                e[i*8+:8] = pass_e[i] ? b : `EPF_DISRUPT;
            check(txd, e);
            if (first)
                check(exp_out, any_e);
            first = 1'b0;
        end
        if (tx_end === 1'b1)
        begin
            check(pay.size(), 0);
            done = 1'b1;
        end
    end
// ==========================================
// stimulus and reference model
    task automatic send_pkt(input int n);
        logic [47:0]  da;
        logic [N-1:0] m;
        logic [7:0]   b;
        int           p;
        int           len;
        p = $urandom % N;
        len = (n % 6 == 5) ? 4 : 8;
        prot = ($urandom % 4) != 0;
        pmask = N'($urandom & $urandom);
        mmask = N'($urandom);
        pnm = N'($urandom);
        want = 1'($urandom);
        slow = 1'($urandom);
        for (int i = 0; i < N; i++)
        begin
            lsa[i*48+:48] = 48'({$urandom, $urandom});
            psa[i*48+:48] = 48'({$urandom, $urandom});
        end
        da = 48'({$urandom, $urandom});
        if (n % 6 == 1) da = `EPF_BCAST_ADDR;
        if (n % 6 == 2) da[`EPF_MCAST_BIT] = 1'b1;
        if (n % 6 == 3) da = lsa[p*48+:48];
        if (n % 6 == 4) da = psa[p*48+:48];
        for (int i = 0; i < N; i++)
            m[i] = (da == lsa[i*48+:48]) || (da == psa[i*48+:48]);
        any_e = |m;
        for (int i = 0; i < N; i++)
            pass_e[i] = !prot || da == `EPF_BCAST_ADDR || pmask[i]
                || (da[`EPF_MCAST_BIT] && mmask[i]) || m[i]
                || (pnm[i] && !(any_e || want));
        // a runt never completes its address, so it leaves unaltered
        if (len < `EPF_DA_BYTES)
        begin
            pass_e = '1;
            any_e = 1'b0;
        end
        pay.delete();
        first = 1'b1;
        done = 1'b0;
        for (int j = 0; j < len; j++)
        begin
            b = (j < 6) ? da[47-8*j-:8] : 8'($urandom);
            pay.push_back(b);
            sof = (j == 0);
            vld = 1'b1;
            rxd = b;
            @(posedge clk);
            #1 sof = 1'b0;
            vld = 1'b0;
            repeat (2) @(posedge clk);
            #1;
        end
        // end strobe keeps the three cycle spacing after the last byte
        eop = 1'b1;
        @(posedge clk);
        #1 eop = 1'b0;
        for (int w = 0; w < 100 && !done; w++)
        begin
            @(posedge clk);
            #1;
        end
        if (!done)
        begin
            failures++;
            hung = 1'b1;
        end
        $display("test %0d done", n);
    endtask

    initial
    begin
        {sof, vld, eop, prot, want, slow, rxd} = 14'h0000;
        {pmask, mmask, pnm, lsa, psa} = '0;
        hung = 1'b0;
        rst = 1'b1;
        void'($urandom(28));
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        check({tx_vld, tx_end, exp_out, txd}, 64'h0);
        // first start strobe only after one edge with reset low
        @(posedge clk);
        #1;
        for (int n = 0; n < 30 && !hung; n++)
            send_pkt(n);
        wrap_up();
    end
endmodule
`default_nettype wire
